/* File: hw/tig_defs.svh */
// Constants for the touch interrupt and pin controller: register offsets,
// field positions, mode codes and reset values.
// Assumes inclusion by bare name from the package and the modules.
`ifndef TIG_DEFS_SVH
`define TIG_DEFS_SVH

// ----------------------------------------
// Register offsets (10-bit register address)
// ----------------------------------------
`define TIG_ADDR_TOUCH_EN_A    10'h005
`define TIG_ADDR_TOUCH_EN_B    10'h006
`define TIG_ADDR_CONV_EN       10'h007
`define TIG_ADDR_TOUCH_ST_A    10'h008
`define TIG_ADDR_TOUCH_ST_B    10'h009
`define TIG_ADDR_CONV_ST       10'h00A

// ----------------------------------------
// Field positions
// ----------------------------------------
`define TIG_SETUP_HI           13
`define TIG_SETUP_LO           12
`define TIG_TRIG_HI            15
`define TIG_TRIG_LO            14
`define TIG_PIN_EN_BIT         12
`define TIG_PIN_ST_BIT         12
`define TIG_NUM_STAGES         12

// ----------------------------------------
// Mode codes
// ----------------------------------------
`define TIG_SETUP_OFF          2'h0
`define TIG_SETUP_IN           2'h1
`define TIG_SETUP_OUT_LO       2'h2
`define TIG_SETUP_OUT_HI       2'h3
`define TIG_TRIG_LOW_LVL       2'h0
`define TIG_TRIG_RISE          2'h1
`define TIG_TRIG_FALL          2'h2
`define TIG_TRIG_HIGH_LVL      2'h3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define TIG_RST_WORD           16'h0000
`define TIG_RST_STAGES         12'h000

`endif

/* File: hw/tig_irq_ctrl.sv */
// Interrupt aggregation and pin control for the touch controller.
// Assumes the serial host interface delivers a register address strobe
// as soon as the read address is known, and data strobes afterwards.
`timescale 1ns/1ps
`include "tig_defs.svh"

module tig_irq_ctrl import tig_pkg::*; (
    input wire logic clock,
    input wire logic sys_rst,
    // Register access from the serial host interface
    input wire logic reg_addr_valid,  // Pulse: read/write address established
    input wire logic reg_read,        // Access is a read
    input wire logic [9:0] reg_addr,  // Register address
    input wire logic reg_wr_en,       // Pulse: write data word ready
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,    // Read data, valid from cycle after address
    // Event sources from the conversion and threshold logic
    input wire logic [11:0] stage_done,    // Pulse per stage: conversion complete
    input wire logic [11:0] stage_done_hold, // Completion condition still present
    input wire logic [11:0] touch_active_a,  // Present activation, first group
    input wire logic [11:0] touch_active_b,  // Present activation, second group
    // Interrupt pin, open drain
    output logic irq_n_out,           // Always low when driving
    output logic irq_n_oe,            // High while pulling line low
    // General-purpose pin
    input wire logic gpio_in,
    output logic gpio_out,
    output logic gpio_oe
);

    // ------------------------------------------------
    // State
    // ------------------------------------------------
    typedef struct packed {
        logic [15:0] touch_en_a;   // Touch enables, first group
        logic [15:0] touch_en_b;   // Touch enables, second group, plus pin setup
        logic [15:0] conv_en;      // Completion enables plus pin enable
        logic [11:0] conv_st;      // Sticky completion status
        logic pin_st;              // Sticky pin status
        logic [11:0] touch_seen_a; // Activation snapshot last reported
        logic [11:0] touch_seen_b;
        logic touch_pend;          // Touch change awaiting a status read
        logic [15:0] rdata;        // Read data output register
        logic irq_oe;              // Interrupt pin drive
        logic gpio_o;              // Pin output level
        logic gpio_e;              // Pin output enable
    } tig_ctrl_type;

    tig_ctrl_type ctrl_reg, ctrl_next;

    // Pin detector wiring
    logic pin_trig;        // Pin condition hit
    logic pin_active;      // Pin level condition still present
    logic pin_armed;       // Pin configured as input
    logic [1:0] pin_setup; // Pin mode field
    logic [1:0] pin_trig_mode;

    // Setup field sits in the touch enable register
    assign pin_setup = ctrl_reg.touch_en_b[`TIG_SETUP_HI:`TIG_SETUP_LO];
    assign pin_trig_mode = ctrl_reg.touch_en_b[`TIG_TRIG_HI:`TIG_TRIG_LO];
    assign pin_armed = (pin_setup == `TIG_SETUP_IN);

    // ------------------------------------------------
    // Pin event detection
    // ------------------------------------------------
    tig_pin_event u_pin_event (
        .clock(clock),
        .sys_rst(sys_rst),
        .pin_in(gpio_in),
        .armed(pin_armed),
        .trig_mode(pin_trig_mode),
        .trig_pulse(pin_trig),
        .cond_active(pin_active)
    );

    // ------------------------------------------------
    // Next state
    // ------------------------------------------------
    logic rd_touch;      // Read of either touch status register
    logic rd_conv;       // Read of completion status
    logic touch_change;  // Any activation differs from last reported
    logic [11:0] conv_en_stages;
    logic any_irq;

    always_comb begin
        ctrl_next = ctrl_reg;
        conv_en_stages = ctrl_reg.conv_en[`TIG_NUM_STAGES-1:0];

        // Reads clear status as soon as the address is set up
        rd_conv = reg_addr_valid & reg_read & (reg_addr == `TIG_ADDR_CONV_ST);
        rd_touch = reg_addr_valid & reg_read &
            ((reg_addr == `TIG_ADDR_TOUCH_ST_A) | (reg_addr == `TIG_ADDR_TOUCH_ST_B));

        // Touch start and end both show as a change
        touch_change = (touch_active_a != ctrl_reg.touch_seen_a) |
            (touch_active_b != ctrl_reg.touch_seen_b);

        // Register writes steer enables and pin setup
        if (reg_wr_en) begin
            case (reg_addr)
                `TIG_ADDR_TOUCH_EN_A: begin
                    ctrl_next.touch_en_a = reg_wdata;
                end
                `TIG_ADDR_TOUCH_EN_B: begin
                    ctrl_next.touch_en_b = reg_wdata;
                end
                `TIG_ADDR_CONV_EN: begin
                    ctrl_next.conv_en = reg_wdata;
                end
                default: begin
                    // Status and unmapped writes are ignored
                end
            endcase
        end

        // Completion status: clear on read only where condition gone,
        // then any new completion sets, so set wins over clear
        if (rd_conv) begin
            ctrl_next.conv_st = ctrl_reg.conv_st & stage_done_hold;
        end
        ctrl_next.conv_st = ctrl_next.conv_st | stage_done;

        // Pin status: same clear rule, level condition keeps it set
        if (rd_conv) begin
            ctrl_next.pin_st = ctrl_reg.pin_st & pin_active;
        end
        if (pin_trig) begin
            ctrl_next.pin_st = 1'b1;
        end

        // Touch pending until status is read; a change on the read
        // cycle still re-arms it
        if (rd_touch) begin
            ctrl_next.touch_pend = 1'b0;
        end
        if (touch_change) begin
            ctrl_next.touch_pend = 1'b1;
            ctrl_next.touch_seen_a = touch_active_a;
            ctrl_next.touch_seen_b = touch_active_b;
        end

        // Read data: touch status is present activation, not history
        ctrl_next.rdata = ctrl_reg.rdata;
        if (reg_addr_valid & reg_read) begin
            case (reg_addr)
                `TIG_ADDR_TOUCH_EN_A: begin
                    ctrl_next.rdata = ctrl_reg.touch_en_a;
                end
                `TIG_ADDR_TOUCH_EN_B: begin
                    ctrl_next.rdata = ctrl_reg.touch_en_b;
                end
                `TIG_ADDR_CONV_EN: begin
                    ctrl_next.rdata = ctrl_reg.conv_en;
                end
                `TIG_ADDR_TOUCH_ST_A: begin
                    ctrl_next.rdata = {4'h0,
                        touch_active_a & ctrl_reg.touch_en_a[`TIG_NUM_STAGES-1:0]};
                end
                `TIG_ADDR_TOUCH_ST_B: begin
                    ctrl_next.rdata = {4'h0,
                        touch_active_b & ctrl_reg.touch_en_b[`TIG_NUM_STAGES-1:0]};
                end
                `TIG_ADDR_CONV_ST: begin
                    ctrl_next.rdata = {3'h0, ctrl_reg.pin_st, ctrl_reg.conv_st};
                end
                default: begin
                    // Unmapped address reads as zero
                    ctrl_next.rdata = `TIG_RST_WORD;
                end
            endcase
        end

        // OR of enabled completion and pin sources and of touch_pend, which no enable masks, onto the line
        any_irq = (|(ctrl_next.conv_st & conv_en_stages)) |
            (ctrl_next.pin_st & ctrl_reg.conv_en[`TIG_PIN_EN_BIT]) |
            ctrl_next.touch_pend;
        // Open drain: only ever pull low
        ctrl_next.irq_oe = any_irq;

        // Pin output drive per setup field
        case (pin_setup)
            `TIG_SETUP_OUT_LO: begin
                ctrl_next.gpio_o = 1'b0;
                ctrl_next.gpio_e = 1'b1;
            end
            `TIG_SETUP_OUT_HI: begin
                ctrl_next.gpio_o = 1'b1;
                ctrl_next.gpio_e = 1'b1;
            end
            default: begin
                // Disabled or input: pin released
                ctrl_next.gpio_o = 1'b0;
                ctrl_next.gpio_e = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------
    // State register
    // ------------------------------------------------
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_reg <= '0;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    // Outputs straight from flip-flops, except irq_n_out, which is tied low
    assign reg_rdata = ctrl_reg.rdata;
    assign irq_n_out = 1'b0;
    assign irq_n_oe = ctrl_reg.irq_oe;
    assign gpio_out = ctrl_reg.gpio_o;
    assign gpio_oe = ctrl_reg.gpio_e;
endmodule

/* File: hw/tig_pin_event.sv */
// Pin trigger detector: synchronises the pin and flags the selected
// level or edge condition. Assumes one clock and an async high reset.
`timescale 1ns/1ps
`include "tig_defs.svh"

module tig_pin_event import tig_pkg::*; (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic pin_in,          // Raw pin level
    input wire logic armed,           // Pin configured as input
    input wire logic [1:0] trig_mode, // Trigger selection
    output logic trig_pulse,          // Condition hit this cycle
    output logic cond_active          // Condition still present
);
    tig_pin_state_type state_reg, state_next;
    logic s2;

    // --------------------------------------------
    // Next state
    // --------------------------------------------
    always_comb begin
        state_next = state_reg;
        s2 = state_reg.sync2;
        // First stage only feeds the second stage
        state_next.sync1 = pin_in;
        state_next.sync2 = state_reg.sync1;
        state_next.prev = s2;
        state_next.event_q = 1'b0;
        state_next.active = 1'b0;
        if (armed) begin
            case (trig_mode)
                `TIG_TRIG_LOW_LVL: begin
                    // Held for as long as pin is low
                    state_next.event_q = ~s2;
                    state_next.active = ~s2;
                end
                `TIG_TRIG_RISE: begin
                    // Successive samples compared
                    state_next.event_q = s2 & ~state_reg.prev;
                end
                `TIG_TRIG_FALL: begin
                    state_next.event_q = ~s2 & state_reg.prev;
                end
                `TIG_TRIG_HIGH_LVL: begin
                    state_next.event_q = s2;
                    state_next.active = s2;
                end
                default: begin
                    state_next.event_q = 1'b0;
                end
            endcase
        end
    end

    // --------------------------------------------
    // State register
    // --------------------------------------------
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign trig_pulse = state_reg.event_q;
    assign cond_active = state_reg.active;
endmodule

/* File: hw/tig_pkg.sv */
// Types shared by the touch interrupt and pin controller.
// Assumes tig_defs.svh is on the include path.
`include "tig_defs.svh"

package tig_pkg;
    // Pin input trigger modes
    typedef enum logic [1:0] {
        TIG_TRIG_LOW_LVL_E,
        TIG_TRIG_RISE_E,
        TIG_TRIG_FALL_E,
        TIG_TRIG_HIGH_LVL_E
    } tig_trig_type;

    // State of the pin event detector
    typedef struct packed {
        logic sync1;   // First synchroniser stage
        logic sync2;   // Second synchroniser stage
        logic prev;    // Previous synchronised sample
        logic event_q; // Registered trigger condition
        logic active;  // Condition still present
    } tig_pin_state_type;
endpackage

/* File: verif/test_touch_irq_and_gpio_ctrl.sv */
// Self-checking bench for tig_irq_ctrl through its register strobes.
// Assumes tig_host_model resolves the interrupt wire and the pin.
`timescale 1ns/1ps
`include "tig_defs.svh"

module test_touch_irq_and_gpio_ctrl;
    logic clock = 1'h0;
    logic sys_rst = 1'h1;
    logic reg_addr_valid = 1'h0;
    logic reg_read = 1'h0;
    logic [9:0] reg_addr = 10'h000;
    logic reg_wr_en = 1'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic [11:0] stage_done = 12'h000;
    logic [11:0] stage_done_hold = 12'h000;
    logic [11:0] touch_active_a = 12'h000;
    logic [11:0] touch_active_b = 12'h000;
    logic pin_drive = 1'h0; // Outside source on the pin
    logic [15:0] reg_rdata;
    logic irq_n_out, irq_n_oe, gpio_out, gpio_oe, irq_line, gpio_pin;
    logic idle; // Inactive pin level of the trigger under test
    logic [11:0] ta [3] = '{12'h005, 12'h007, 12'h000};
    logic [11:0] tb [3] = '{12'h030, 12'h010, 12'h000};
    logic [15:0] sa [3] = '{16'h0001, 16'h0003, 16'h0000};
    logic [15:0] sb [3] = '{16'h0010, 16'h0010, 16'h0000};
    int error_cnt = 0;
    int num_checks = 0;

    // ----------------------------------------
    // Clock and instances
    // ----------------------------------------
    initial begin
        forever #50 clock = ~clock;
    end
    tig_irq_ctrl i_tig_irq_ctrl (.clock(clock), .sys_rst(sys_rst), .reg_addr_valid(reg_addr_valid),
        .reg_read(reg_read), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .stage_done(stage_done), .stage_done_hold(stage_done_hold),
        .touch_active_a(touch_active_a), .touch_active_b(touch_active_b), .irq_n_out(irq_n_out),
        .irq_n_oe(irq_n_oe), .gpio_in(gpio_pin), .gpio_out(gpio_out), .gpio_oe(gpio_oe));
    tig_host_model i_tig_host_model (.irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe), .gpio_out(gpio_out),
        .gpio_oe(gpio_oe), .pin_drive(pin_drive), .irq_line(irq_line), .gpio_pin(gpio_pin));

    // ----------------------------------------
    // Access and compare tasks
    // ----------------------------------------
    task automatic summarize;
        if (error_cnt == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Write strobe lasts one cycle
    task automatic wr(input logic [9:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_wr_en <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr_en <= 1'h0;
    endtask
    // Read data lands at the edge that takes the address; an empty name only clears status
    task automatic rd(input logic [9:0] a, input logic [15:0] exp, input string name);
        @(posedge clock);
        reg_addr_valid <= 1'h1;
        reg_read <= 1'h1;
        reg_addr <= a;
        @(posedge clock);
        reg_addr_valid <= 1'h0;
        reg_read <= 1'h0;
        #1;
        if (name != "") begin
            chk(name, exp, reg_rdata);
        end
    endtask
    task automatic ick(input logic exp);
        chk("irq line", {15'h0000, exp}, {15'h0000, irq_line});
    endtask
    // Bounded wait for the wire level; running out ends the run
    task automatic wait_irq(input logic exp);
        int n;
        n = 0;
        #1;
        while (irq_line !== exp && n < 12) begin
            @(posedge clock);
            #1;
            n++;
        end
        ick(exp);
        if (irq_line !== exp) begin
            summarize();
        end
    endtask
    task automatic pulse(input logic [11:0] d, input logic [11:0] h);
        @(posedge clock);
        stage_done <= d;
        stage_done_hold <= h;
        @(posedge clock);
        stage_done <= 12'h000;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (2) @(posedge clock);
        sys_rst <= 1'h0;
        #1;
        ick(1'h1);
        chk("pin oe", 16'h0000, {15'h0000, gpio_oe});
        wr(`TIG_ADDR_TOUCH_EN_A, 16'h0003);
        rd(`TIG_ADDR_TOUCH_EN_A, 16'h0003, "touch en a");
        wr(`TIG_ADDR_TOUCH_EN_B, 16'h0010);
        rd(`TIG_ADDR_TOUCH_EN_B, 16'h0010, "touch en b");
        wr(10'h00B, 16'hFFFF);
        rd(10'h00B, 16'h0000, "unmapped");
        // Touch start, count change and release each interrupt; reads show present state
        for (int i = 0; i < 3; i++) begin
            @(posedge clock);
            touch_active_a <= ta[i];
            touch_active_b <= tb[i];
            wait_irq(1'h0);
            // Line must stay low with no status read in between
            repeat (3) @(posedge clock);
            #1;
            ick(1'h0);
            rd(`TIG_ADDR_TOUCH_ST_A, sa[i], "touch st a");
            ick(1'h1);
            rd(`TIG_ADDR_TOUCH_ST_B, sb[i], "touch st b");
        end
        // Completion: plain clear, then a held condition that survives a read
        wr(`TIG_ADDR_CONV_EN, 16'h0004);
        rd(`TIG_ADDR_CONV_EN, 16'h0004, "conv en");
        pulse(12'h004, 12'h000);
        wait_irq(1'h0);
        rd(`TIG_ADDR_CONV_ST, 16'h0004, "conv st");
        ick(1'h1);
        pulse(12'h004, 12'h004);
        wait_irq(1'h0);
        rd(`TIG_ADDR_CONV_ST, 16'h0004, "conv st held");
        ick(1'h0);
        @(posedge clock);
        stage_done_hold <= 12'h000;
        rd(`TIG_ADDR_CONV_ST, 16'h0004, "conv st last");
        rd(`TIG_ADDR_CONV_ST, 16'h0000, "conv st clear");
        ick(1'h1);
        // Output modes low, high, then disabled
        for (int m = 0; m < 3; m++) begin
            wr(`TIG_ADDR_TOUCH_EN_B, {2'h0, 2'(m + 2), 12'h000});
            @(posedge clock);
            #1;
            chk("pin drive", {14'h0000, m < 2, m == 1}, {14'h0000, gpio_oe, gpio_oe & gpio_pin});
        end
        // Each trigger mode: idle clears, active asserts, read shows level or edge behaviour
        wr(`TIG_ADDR_CONV_EN, 16'h1000);
        for (int t = 0; t < 4; t++) begin
            idle = (t == 0 || t == 2);
            @(posedge clock);
            pin_drive <= idle;
            wr(`TIG_ADDR_TOUCH_EN_B, {2'(t), 2'h1, 12'h000});
            repeat (6) @(posedge clock);
            rd(`TIG_ADDR_CONV_ST, 16'h0000, "");
            rd(`TIG_ADDR_CONV_ST, 16'h0000, "pin idle");
            @(posedge clock);
            pin_drive <= !idle;
            wait_irq(1'h0);
            rd(`TIG_ADDR_CONV_ST, 16'h1000, "pin st");
            ick(t == 1 || t == 2);
            @(posedge clock);
            pin_drive <= idle;
            repeat (6) @(posedge clock);
            rd(`TIG_ADDR_CONV_ST, 16'h0000, "");
        end
        // Pin disabled, pin interrupt masked, and a masked stage all stay silent
        wr(`TIG_ADDR_TOUCH_EN_B, 16'hC000);
        @(posedge clock);
        pin_drive <= 1'h1;
        repeat (6) @(posedge clock);
        #1;
        ick(1'h1);
        wr(`TIG_ADDR_CONV_EN, 16'h0000);
        wr(`TIG_ADDR_TOUCH_EN_B, 16'hD000);
        pulse(12'h020, 12'h000);
        repeat (6) @(posedge clock);
        #1;
        ick(1'h1);
        summarize();
    end
endmodule

/* File: verif/tig_host_model.sv */
// Far-side model: the host's pull-up on the interrupt line and the board around the pin.
// Assumes the bench drives pin_drive whenever the device does not drive the pin.
`timescale 1ns/1ps

module tig_host_model (
    input wire logic irq_n_out,
    input wire logic irq_n_oe,
    input wire logic gpio_out,
    input wire logic gpio_oe,
    input wire logic pin_drive,  // Outside source on the pin
    output logic irq_line,       // Resolved interrupt wire
    output logic gpio_pin        // Resolved pin wire
);
    // ----------------------------------------
    // Wire resolution
    // ----------------------------------------
    // Pull-up wins whenever the device lets go, so a stuck enable shows at once
    assign irq_line = irq_n_oe ? irq_n_out : 1'h1;
    // The device owns the pin only while it drives it
    assign gpio_pin = gpio_oe ? gpio_out : pin_drive;
endmodule

/* File: verif/tig_irq_ctrl_checker.sv */
// Port-level checks for tig_irq_ctrl, bound to every instance.
// Assumes one clock and the async active-high reset of the block.
`timescale 1ns/1ps
`include "tig_defs.svh"

module tig_irq_ctrl_checker import tig_pkg::*; (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic reg_addr_valid,
    input wire logic reg_read,
    input wire logic [9:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic [11:0] stage_done,
    input wire logic [11:0] stage_done_hold,
    input wire logic [11:0] touch_active_a,
    input wire logic [11:0] touch_active_b,
    input wire logic irq_n_out,
    input wire logic irq_n_oe,
    input wire logic gpio_in,
    input wire logic gpio_out,
    input wire logic gpio_oe
);
    // ----------------------------------------
    // Shadow of the configuration writes
    // ----------------------------------------
    logic [15:0] conv_en_reg; // Copy of the conversion enable word
    logic [15:0] pin_cfg_reg; // Copy of the second touch enable word
    // Mirrors writes only, since the bodies are not visible from here
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            conv_en_reg <= 16'h0000;
            pin_cfg_reg <= 16'h0000;
        end else if (reg_wr_en) begin
            if (reg_addr == `TIG_ADDR_CONV_EN) begin
                conv_en_reg <= reg_wdata;
            end
            if (reg_addr == `TIG_ADDR_TOUCH_EN_B) begin
                pin_cfg_reg <= reg_wdata;
            end
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    // ----------------------------------------
    // Sequences
    // ----------------------------------------
    // Touch status read with every other source switched off
    sequence touch_read_s;
        reg_addr_valid && reg_read && !reg_wr_en && conv_en_reg == 16'h0000 &&
            (reg_addr == `TIG_ADDR_TOUCH_ST_A || reg_addr == `TIG_ADDR_TOUCH_ST_B) &&
            !$changed(touch_active_a) && !$changed(touch_active_b);
    endsequence
    // Pin held high in high-level input mode with its interrupt enabled
    sequence level_high_s;
        (pin_cfg_reg[15:12] == 4'hD && conv_en_reg[12] && gpio_in)[*6];
    endsequence

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    open_drain_a: assert property (irq_n_out == 1'h0)
        else $error("interrupt data is not low");
    pin_drive_a: assert property ($stable(pin_cfg_reg[13:12]) |->
        gpio_oe == pin_cfg_reg[13] && (!gpio_oe || gpio_out == pin_cfg_reg[12]))
        else $error("pin drive does not follow setup");
    touch_change_a: assert property ($changed(touch_active_a) || $changed(touch_active_b) |=> irq_n_oe)
        else $error("touch change did not assert interrupt");
    irq_hold_a: assert property (irq_n_oe && !reg_addr_valid && !reg_wr_en |=> irq_n_oe)
        else $error("interrupt dropped without a read");
    touch_clear_a: assert property (touch_read_s |=> !irq_n_oe)
        else $error("touch read did not release interrupt");
    conv_set_a: assert property ((stage_done & conv_en_reg[11:0]) != 12'h000 |-> ##[1:2] irq_n_oe)
        else $error("enabled completion did not assert interrupt");
    pin_level_a: assert property (level_high_s |-> irq_n_oe)
        else $error("active pin level did not assert interrupt");
    rdata_hold_a: assert property (!(reg_addr_valid && reg_read) |=> $stable(reg_rdata))
        else $error("read data moved without a read");
endmodule

bind tig_irq_ctrl tig_irq_ctrl_checker i_tig_irq_ctrl_checker (.clock(clock), .sys_rst(sys_rst),
    .reg_addr_valid(reg_addr_valid), .reg_read(reg_read), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .stage_done(stage_done), .stage_done_hold(stage_done_hold),
    .touch_active_a(touch_active_a), .touch_active_b(touch_active_b), .irq_n_out(irq_n_out),
    .irq_n_oe(irq_n_oe), .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe));
